// ==== hw/bmss_pkg.sv ====
package bmss_pkg;
  // time base
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ACCEL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RATE = 8'h0C;

  // control register fields (lsb positions)
  localparam int CTRL_ISD_EN = 0;
  localparam int CTRL_REV_EN = 1;
  localparam int CTRL_REL_MODE = 2;
  localparam int CTRL_PULSE_RATE = 3;
  localparam int CTRL_STAT_THR = 5;
  localparam int CTRL_REV_LIMIT = 7;
  localparam int CTRL_BRAKE_TIME = 10;
  localparam int CTRL_IPD_CURR = 13;
  localparam int CTRL_ALIGN = 17;
  localparam int CTRL_OL_CURR = 20;
  localparam logic [31:0] CTRL_MASK = 32'h003F_FFFF;
  localparam logic [31:0] CTRL_RESET = 32'h0012_0001;

  // acceleration register fields
  localparam int ACC_FIRST = 0;
  localparam int ACC_SECOND = 3;
  localparam int ACC_HANDOFF = 6;
  localparam logic [31:0] ACCEL_MASK = 32'h0000_07FF;
  localparam logic [31:0] ACCEL_RESET = 32'h0000_010B;
  localparam int HANDOFF_SHIFT = 8;

  // status register fields
  localparam int STAT_STATE = 0;
  localparam int STAT_REV = 8;
  localparam int STAT_SECTOR = 9;
  localparam int STAT_PERIOD = 12;

  // durations in ticks of TICK_TIME_NS
  localparam logic [15:0] STAT_MS [4] = '{16'h0032, 16'h0064, 16'h00C8, 16'h0190};
  localparam logic [15:0] REV_LIMIT_MS [8] = '{16'h00C8, 16'h0064, 16'h0032, 16'h0019,
                                                16'h000C, 16'h0006, 16'h0003, 16'h0002};
  localparam logic [15:0] BRAKE_MS [8] = '{16'h0000, 16'h000A, 16'h0032, 16'h0064,
                                            16'h00C8, 16'h012C, 16'h01F4, 16'h03E8};
  localparam logic [15:0] ALIGN_MS [8] = '{16'h0028, 16'h0050, 16'h00A0, 16'h0140,
                                            16'h0280, 16'h0500, 16'h0A50, 16'h14B4};
  // position pulse release waits in clock cycles
  localparam logic [11:0] IPD_REL_CYC [4] = '{12'h100, 12'h200, 12'h400, 12'h800};
  localparam logic [11:0] IPD_PULSE_MAX = 12'hFFF;
  localparam logic [15:0] RATE_NUM = 16'hFFFF;

  // six-step pairs, bit0 U, bit1 V, bit2 W: UV UW VW VU WU WV
  localparam logic [2:0] SIX_HS [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
  localparam logic [2:0] SIX_LS [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
  // pulse order VW WV UV VU WU UW as six-step indices
  localparam logic [2:0] IPD_SECTOR [6] = '{3'h2, 3'h5, 3'h0, 3'h3, 3'h4, 3'h1};
  localparam logic [2:0] ALIGN_SECTOR = 3'h2;

  typedef enum logic [7:0] {
    ST_POWER_ON = 8'h01,
    ST_ISD = 8'h02,
    ST_BRAKE = 8'h04,
    ST_ALIGN = 8'h08,
    ST_IPD = 8'h10,
    ST_REV_DRIVE = 8'h20,
    ST_ACCEL = 8'h40,
    ST_CLOSED = 8'h80
  } bmss_state_t;
endpackage : bmss_pkg

// ==== hw/bmss_top.sv ====
// Overview of operation
// [R1] Start in power-on state after reset and whenever standby or sleep ends.
// [R2] Power-on goes to speed detect if enabled, else to brake decision.
// [R3] Speed below stationary threshold leads to brake decision, else direction decision.
// [R4] Forward rotation resynchronises straight into closed loop; reverse checks speed limit.
// [R5] Reverse faster than limit returns to speed detect; else reverse-drive decision.
// [R6] Reverse drive enabled enters reverse drive, else brake decision.
// [R7] Reverse drive pushes forward until zero speed, then accelerates.
// [R8] Nonzero brake time enables braking and enters brake state.
// [R9] Brake turns on all three low-side switches together.
// [R10] Brake lasts the selected time, then position-detect decision.
// [R11] Brake disabled skips brake and starts as if stationary.
// [R12] Nonzero pulse current limit selects position detect, otherwise align.
// [R13] Align drives into V, out of W at open-loop current for align time.
// [R14] Accelerate with first and second order rates until handoff threshold, then closed loop.
// [R15] Direction pin change stops driving and restarts the sequence.
// [R16] Speed detect keeps all phases high impedance while comparators watch back-EMF.
// [R17] UW lagging UV means forward; UW leading UV means reverse.
// [R18] Speed comes from time between consecutive rising comparator edges.
// [R19] No comparator toggle within threshold time means stationary; the code counts only rising edges, falling edges do not restart the timer.
// [R20] Resync loads measured speed and position into the drive state.
// [R21] Pulse pairs VW WV UV VU WU UW, timed; shortest gives position, then accelerate.
// [R22] Release mode 0 keeps the low-side on; mode 1 turns both off.
// [R23] All timing counters run on the clock and clear on restart.
//
// The register offsets and the APB interface to the registers were decided locally.
module bmss_top
  import bmss_pkg::*;
#(
  parameter int P_TICK_CYCLES = TICK_CYCLES
)
(
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic I_STANDBY,
  input wire logic I_DIR,
  input wire logic I_CMP_UV,
  input wire logic I_CMP_UW,
  input wire logic I_CURR_HIT,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [2:0] O_HS_ON,
  output logic [2:0] O_LS_ON,
  output logic O_PHASE_HIZ,
  output logic O_CURR_LIMIT_EN,
  output logic [1:0] O_CURR_LIMIT_SEL,
  output logic [3:0] O_PULSE_CURR_LIMIT,
  output logic O_CLOSED_LOOP,
  output logic [2:0] O_ROTOR_SECTOR
);
  logic [31:0] ctrl_q, ctrl_d, accel_q, accel_d, prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  bmss_state_t state_q, state_d;
  logic [15:0] presc_q, presc_d, tmr_q, tmr_d, period_q, period_d, per;
  logic [15:0] rate_q, rate_d, acc2_q, acc2_d, dec, handoff_lim;
  logic [19:0] ph_q, ph_d;
  logic [20:0] ph_sum;
  logic [2:0] sector_q, sector_d, ipd_idx_q, ipd_idx_d, best_idx_q, best_idx_d;
  logic [11:0] cyc_q, cyc_d, best_q, best_d;
  logic ipd_rel_q, ipd_rel_d, seen_q, seen_d, dirk_q, dirk_d, rev_q, rev_d;
  logic uv_q, uw_q, dir_q;
  logic [2:0] hs_q, hs_d, ls_q, ls_d;
  logic hiz_q, hiz_d, clim_q, clim_d, closed_q, closed_d;
  logic tick, restart, dir_chg, uv_rise, uw_rise, edge_any, isd_timeout, decide, rev_now;
  logic access, mapped;

  logic isd_en, rev_en, rel_mode;
  logic [1:0] pulse_rate, stat_thr, ol_curr;
  logic [2:0] rev_limit, brake_time, align_sel, acc1, acc2sel;
  logic [3:0] ipd_curr;
  logic [4:0] handoff;

  assign isd_en = ctrl_q[CTRL_ISD_EN];
  assign rev_en = ctrl_q[CTRL_REV_EN];
  assign rel_mode = ctrl_q[CTRL_REL_MODE];
  assign pulse_rate = ctrl_q[CTRL_PULSE_RATE +: 2];
  assign stat_thr = ctrl_q[CTRL_STAT_THR +: 2];
  assign rev_limit = ctrl_q[CTRL_REV_LIMIT +: 3];
  assign brake_time = ctrl_q[CTRL_BRAKE_TIME +: 3];
  assign ipd_curr = ctrl_q[CTRL_IPD_CURR +: 4];
  assign align_sel = ctrl_q[CTRL_ALIGN +: 3];
  assign ol_curr = ctrl_q[CTRL_OL_CURR +: 2];
  assign acc1 = accel_q[ACC_FIRST +: 3];
  assign acc2sel = accel_q[ACC_SECOND +: 3];
  assign handoff = accel_q[ACC_HANDOFF +: 5];
  assign handoff_lim = 16'(handoff) << HANDOFF_SHIFT;
  assign dec = {13'h0000, acc1} + 16'h0001;

  // apb slave: one wait state so every answer comes from a flop
  assign access = I_PSEL & I_PENABLE & ~pready_q;
  assign mapped = (I_PADDR == ADDR_CTRL) | (I_PADDR == ADDR_ACCEL) |
                  (I_PADDR == ADDR_STATUS) | (I_PADDR == ADDR_RATE);

  always_comb
  begin
    ctrl_d = ctrl_q;
    accel_d = accel_q;
    prdata_d = prdata_q;
    pready_d = access;
    pslverr_d = access & ~mapped;
    // writes land on the completing edge, while the master still holds address and data
    if (I_PSEL && I_PENABLE && pready_q && I_PWRITE)
    begin
      if (I_PADDR == ADDR_CTRL)
        ctrl_d = I_PWDATA & CTRL_MASK;
      if (I_PADDR == ADDR_ACCEL)
        accel_d = I_PWDATA & ACCEL_MASK;
    end
    if (access && !I_PWRITE)
    begin
      case (I_PADDR)
        ADDR_CTRL: prdata_d = ctrl_q;
        ADDR_ACCEL: prdata_d = accel_q;
        ADDR_STATUS: prdata_d = {4'h0, period_q, sector_q, rev_q, state_q};
        ADDR_RATE: prdata_d = {16'h0000, rate_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      ctrl_q <= CTRL_RESET;
      accel_q <= ACCEL_RESET;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      accel_q <= accel_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // sequencer helpers
  assign tick = (presc_q == 16'(P_TICK_CYCLES - 1));
  assign dir_chg = (I_DIR != dir_q);
  assign restart = I_STANDBY | dir_chg; // see [R1] [R15]
  assign uv_rise = I_CMP_UV & ~uv_q;
  assign uw_rise = I_CMP_UW & ~uw_q;
  assign edge_any = uv_rise | uw_rise;
  assign isd_timeout = (state_q == ST_ISD) && !edge_any && (tmr_q >= STAT_MS[stat_thr]); // see [R19]
  assign decide = (state_q == ST_ISD) && edge_any && seen_q && (dirk_q || uv_rise);
  // at a UV rise, UW still low means UW lags by 60 degrees
  assign rev_now = uv_rise ? (I_CMP_UW ^ dir_q) : rev_q; // see [R17]
  assign per = (tmr_q == 16'h0000) ? 16'h0001 : tmr_q; // see [R18]
  assign ph_sum = {1'b0, ph_q} + {5'h00, rate_q};

  // stationary path: brake if enabled, then position detect or align
  function automatic bmss_state_t stationary_next(input logic [2:0] bt, input logic [3:0] ic);
    if (bt != 3'h0)
      return ST_BRAKE; // see [R8]
    else if (ic != 4'h0)
      return ST_IPD; // see [R11] [R12]
    else
      return ST_ALIGN;
  endfunction : stationary_next

  always_comb
  begin
    state_d = state_q;
    presc_d = tick ? 16'h0000 : presc_q + 16'h0001;
    tmr_d = (tick && tmr_q != 16'hFFFF) ? tmr_q + 16'h0001 : tmr_q;
    period_d = period_q;
    rate_d = rate_q;
    acc2_d = acc2_q;
    ph_d = ph_q;
    sector_d = sector_q;
    ipd_idx_d = ipd_idx_q;
    ipd_rel_d = ipd_rel_q;
    cyc_d = cyc_q;
    best_d = best_q;
    best_idx_d = best_idx_q;
    seen_d = seen_q;
    dirk_d = dirk_q;
    rev_d = rev_q;
    case (state_q)
      ST_POWER_ON:
        state_d = isd_en ? ST_ISD : stationary_next(brake_time, ipd_curr); // see [R2]
      ST_ISD:
      begin
        if (isd_timeout)
          state_d = stationary_next(brake_time, ipd_curr); // see [R3]
        else if (edge_any)
        begin
          tmr_d = 16'h0000;
          seen_d = 1'b1;
          if (uv_rise)
          begin
            dirk_d = 1'b1;
            rev_d = rev_now;
          end
          if (decide)
          begin
            period_d = per;
            if (!rev_now)
            begin
              state_d = ST_CLOSED; // see [R4]
              rate_d = RATE_NUM / per; // see [R20]
              sector_d = uv_rise ? 3'h0 : 3'h2;
            end
            else if (per < REV_LIMIT_MS[rev_limit])
            begin
              seen_d = 1'b0; // see [R5]
              dirk_d = 1'b0;
            end
            else if (rev_en)
            begin
              state_d = ST_REV_DRIVE; // see [R6]
              rate_d = RATE_NUM / per;
            end
            else
              state_d = stationary_next(brake_time, ipd_curr);
          end
        end
      end
      ST_BRAKE:
        if (tmr_q >= BRAKE_MS[brake_time])
          state_d = (ipd_curr != 4'h0) ? ST_IPD : ST_ALIGN; // see [R10] [R12]
      ST_ALIGN:
        if (tmr_q >= ALIGN_MS[align_sel])
        begin
          state_d = ST_ACCEL; // see [R13]
          sector_d = ALIGN_SECTOR;
          rate_d = 16'h0000;
        end
      ST_IPD:
      begin
        cyc_d = cyc_q + 12'h001;
        if (!ipd_rel_q)
        begin
          if (I_CURR_HIT || cyc_q == IPD_PULSE_MAX)
          begin
            if (cyc_q < best_q) // see [R21]
            begin
              best_d = cyc_q;
              best_idx_d = ipd_idx_q;
            end
            ipd_rel_d = 1'b1;
            cyc_d = 12'h000;
          end
        end
        else if (cyc_q >= IPD_REL_CYC[pulse_rate])
        begin
          ipd_rel_d = 1'b0;
          cyc_d = 12'h000;
          if (ipd_idx_q == 3'h5)
          begin
            state_d = ST_ACCEL;
            sector_d = IPD_SECTOR[best_idx_q];
            rate_d = 16'h0000;
          end
          else
            ipd_idx_d = ipd_idx_q + 3'h1;
        end
      end
      ST_REV_DRIVE:
      begin
        // motor still turns backwards, so the sector tracks backwards
        ph_d = ph_sum[19:0];
        if (ph_sum[20])
          sector_d = (sector_q == 3'h0) ? 3'h5 : sector_q - 3'h1;
        if (tick)
        begin
          if (rate_q <= dec)
          begin
            rate_d = 16'h0000;
            state_d = ST_ACCEL; // see [R7]
          end
          else
            rate_d = rate_q - dec;
        end
      end
      ST_ACCEL, ST_CLOSED:
      begin
        ph_d = ph_sum[19:0];
        if (ph_sum[20])
          sector_d = (sector_q == 3'h5) ? 3'h0 : sector_q + 3'h1;
        if (state_q == ST_ACCEL)
        begin
          if (rate_q > handoff_lim)
            state_d = ST_CLOSED; // see [R14]
          else if (tick)
          begin
            // saturate so a slow handoff setting cannot wrap the rate
            acc2_d = (acc2_q > 16'hEFFF) ? acc2_q : acc2_q + {13'h0000, acc2sel};
            if ({1'b0, rate_q} + {1'b0, acc2_q} + 17'(acc1) > 17'h0FFFF)
              rate_d = 16'hFFFF;
            else
              rate_d = rate_q + acc2_q + {13'h0000, acc1};
          end
        end
      end
      default:
        state_d = ST_POWER_ON;
    endcase
    if (state_d != state_q)
    begin
      tmr_d = 16'h0000;
      presc_d = 16'h0000;
      cyc_d = 12'h000;
      ipd_idx_d = 3'h0;
      ipd_rel_d = 1'b0;
      best_d = IPD_PULSE_MAX;
      acc2_d = 16'h0000;
      ph_d = 20'h00000;
      seen_d = 1'b0;
      dirk_d = 1'b0;
    end
    if (restart)
    begin
      state_d = ST_POWER_ON; // see [R1] [R15]
      tmr_d = 16'h0000; // see [R23]
      presc_d = 16'h0000;
      cyc_d = 12'h000;
      rate_d = 16'h0000;
      acc2_d = 16'h0000;
      ph_d = 20'h00000;
      seen_d = 1'b0;
      dirk_d = 1'b0;
    end
  end

  // drive pattern, one cycle behind the state
  always_comb
  begin
    hs_d = 3'h0;
    ls_d = 3'h0;
    hiz_d = 1'b0;
    clim_d = 1'b0;
    case (state_q)
      ST_POWER_ON, ST_ISD:
        hiz_d = 1'b1; // see [R16]
      ST_BRAKE:
        ls_d = 3'h7; // see [R9]
      ST_ALIGN:
      begin
        hs_d = SIX_HS[ALIGN_SECTOR]; // see [R13]
        ls_d = SIX_LS[ALIGN_SECTOR];
        clim_d = 1'b1;
      end
      ST_IPD:
        if (!ipd_rel_q)
        begin
          hs_d = SIX_HS[IPD_SECTOR[ipd_idx_q]]; // see [R21]
          ls_d = SIX_LS[IPD_SECTOR[ipd_idx_q]];
        end
        else if (!rel_mode)
          ls_d = SIX_LS[IPD_SECTOR[ipd_idx_q]]; // see [R22]
      ST_REV_DRIVE, ST_ACCEL, ST_CLOSED:
      begin
        hs_d = SIX_HS[sector_q];
        ls_d = SIX_LS[sector_q];
        clim_d = (state_q != ST_CLOSED);
      end
      default:
        hiz_d = 1'b1;
    endcase
    if (dir_q)
    begin
      // reverse rotation by exchanging V and W
      hs_d = {hs_d[1], hs_d[2], hs_d[0]};
      ls_d = {ls_d[1], ls_d[2], ls_d[0]};
    end
    if (restart)
    begin
      hs_d = 3'h0; // see [R15]
      ls_d = 3'h0;
      hiz_d = 1'b1;
      clim_d = 1'b0;
    end
    closed_d = (state_q == ST_CLOSED) && !restart;
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      state_q <= ST_POWER_ON;
      presc_q <= 16'h0000;
      tmr_q <= 16'h0000;
      period_q <= 16'h0000;
      rate_q <= 16'h0000;
      acc2_q <= 16'h0000;
      ph_q <= 20'h00000;
      sector_q <= 3'h0;
      ipd_idx_q <= 3'h0;
      ipd_rel_q <= 1'b0;
      cyc_q <= 12'h000;
      best_q <= IPD_PULSE_MAX;
      best_idx_q <= 3'h0;
      seen_q <= 1'b0;
      dirk_q <= 1'b0;
      rev_q <= 1'b0;
      uv_q <= 1'b0;
      uw_q <= 1'b0;
      dir_q <= 1'b0;
      hs_q <= 3'h0;
      ls_q <= 3'h0;
      hiz_q <= 1'b1;
      clim_q <= 1'b0;
      closed_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      presc_q <= presc_d;
      tmr_q <= tmr_d;
      period_q <= period_d;
      rate_q <= rate_d;
      acc2_q <= acc2_d;
      ph_q <= ph_d;
      sector_q <= sector_d;
      ipd_idx_q <= ipd_idx_d;
      ipd_rel_q <= ipd_rel_d;
      cyc_q <= cyc_d;
      best_q <= best_d;
      best_idx_q <= best_idx_d;
      seen_q <= seen_d;
      dirk_q <= dirk_d;
      rev_q <= rev_d;
      uv_q <= I_CMP_UV;
      uw_q <= I_CMP_UW;
      dir_q <= I_DIR;
      hs_q <= hs_d;
      ls_q <= ls_d;
      hiz_q <= hiz_d;
      clim_q <= clim_d;
      closed_q <= closed_d;
    end
  end

  assign O_PRDATA = prdata_q;
  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;
  assign O_HS_ON = hs_q;
  assign O_LS_ON = ls_q;
  assign O_PHASE_HIZ = hiz_q;
  assign O_CURR_LIMIT_EN = clim_q;
  assign O_CURR_LIMIT_SEL = ctrl_q[CTRL_OL_CURR +: 2];
  assign O_PULSE_CURR_LIMIT = ctrl_q[CTRL_IPD_CURR +: 4];
  assign O_CLOSED_LOOP = closed_q;
  assign O_ROTOR_SECTOR = sector_q;

  a_standby_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // see [R1]
    I_STANDBY |=> state_q == ST_POWER_ON && hs_q == 3'h0 && ls_q == 3'h0)
    else $error("standby did not hold power-on state");
  a_isd_enable_check: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // see [R2]
    (state_q == ST_POWER_ON && !restart && isd_en) |=> state_q == ST_ISD)
    else $error("speed detect not entered");
  a_skip_to_brake: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // see [R8]
    (state_q == ST_POWER_ON && !restart && !isd_en && brake_time != 3'h0) |=> state_q == ST_BRAKE)
    else $error("brake not entered");
  a_resync_forward: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // see [R4]
    (decide && !rev_now && !restart) |=> state_q == ST_CLOSED ##1 closed_q)
    else $error("forward spin did not resync into closed loop");
  a_stationary_exit: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // see [R19]
    (isd_timeout && !restart) |=> state_q inside {ST_BRAKE, ST_IPD, ST_ALIGN})
    else $error("stationary motor not routed to start path");
  a_isd_outputs_off: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // see [R16]
    (state_q == ST_ISD) |=> (hs_q == 3'h0 && ls_q == 3'h0 && hiz_q))
    else $error("phases driven during speed detect");
  a_brake_low_sides: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // see [R9]
    (state_q == ST_BRAKE && !restart) |=> (ls_q == 3'h7 && hs_q == 3'h0))
    else $error("brake pattern wrong");
  a_brake_duration: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // see [R10]
    (state_q == ST_BRAKE && !restart && tmr_q < BRAKE_MS[brake_time]) |=> state_q == ST_BRAKE)
    else $error("brake ended early");
  a_align_phase_pair: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // see [R13]
    (state_q == ST_ALIGN && !restart && !dir_q) |=> (hs_q == 3'h2 && ls_q == 3'h4 && clim_q))
    else $error("align pattern wrong");
  a_handoff_closed: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // see [R14]
    (state_q == ST_ACCEL && !restart && rate_q > handoff_lim) |=> state_q == ST_CLOSED)
    else $error("handoff to closed loop missed");
  a_dir_restart: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // see [R15]
    dir_chg |=> (state_q == ST_POWER_ON && hs_q == 3'h0 && ls_q == 3'h0 && tmr_q == 16'h0000))
    else $error("direction change did not restart");
  a_release_mode: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // see [R22]
    (state_q == ST_IPD && ipd_rel_q && !restart) |=> (hs_q == 3'h0 && (rel_mode ? ls_q == 3'h0 : ls_q != 3'h0)))
    else $error("pulse release pattern wrong");
endmodule : bmss_top

// ==== sim/bmss_motor.sv ====
module bmss_motor (
  input wire logic i_clk,
  input wire logic i_spin,
  input wire logic i_fwd,
  input wire logic [2:0] i_hs,
  input wire logic [2:0] i_ls,
  output logic o_cmp_uv,
  output logic o_cmp_uw,
  output logic o_curr_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph = 0;
  int cnt = 0;
  int lim;
  always @(posedge i_clk)
  begin
    ph <= (ph + 1) % 96;
    cnt <= (i_hs != 3'h0 && i_ls != 3'h0) ? cnt + 1 : 0;
  end
  // rise time differs per pair so that UV is the shortest pulse
  assign lim = 6 + 2 * int'(i_hs) + int'(i_ls);
  assign o_curr_hit = cnt >= lim;
  // sectors of 16 cycles so even the 60 degree gap spans several ticks; a stopped motor makes no crossings
  assign o_cmp_uv = i_spin && (ph / 16) < 3;
  assign o_cmp_uw = i_spin && (i_fwd ? (ph / 16 + 5) % 6 : (ph / 16 + 1) % 6) < 3;
endmodule : bmss_motor

// ==== sim/tb_top.sv ====
module tb_top;
  import bmss_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic er;} bmss_row_t;
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic stby = 1'h1, dir = 1'h0, spin = 1'h0, fwd = 1'h1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, perr, e, uv, uw, hit, hiz, clen, cl;
  logic [2:0] hs, ls, sec;
  logic [1:0] csel;
  logic [3:0] pcl;
  int fails = 0, n_compared = 0, cyc = 0;
  bmss_row_t rows [8] = '{
    '{1'h0, 8'h00, 32'h0, 32'h0012_0001, 1'h0},
    '{1'h0, 8'h04, 32'h0, 32'h0000_010B, 1'h0},
    '{1'h1, 8'h00, 32'hFFFF_FFFF, 32'h0, 1'h0},
    '{1'h0, 8'h00, 32'h0, 32'h003F_FFFF, 1'h0},
    '{1'h1, 8'h04, 32'hFFFF_FFFF, 32'h0, 1'h0},
    '{1'h0, 8'h04, 32'h0, 32'h0000_07FF, 1'h0},
    '{1'h0, 8'h10, 32'h0, 32'h0, 1'h1},
    '{1'h1, 8'h10, 32'h5, 32'h0, 1'h1}};

  bmss_top #(.P_TICK_CYCLES(4)) dut (.I_CLK_SYS(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_STANDBY(stby), .I_DIR(dir), .I_CMP_UV(uv),
    .I_CMP_UW(uw), .I_CURR_HIT(hit), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(perr),
    .O_HS_ON(hs), .O_LS_ON(ls), .O_PHASE_HIZ(hiz), .O_CURR_LIMIT_EN(clen), .O_CURR_LIMIT_SEL(csel),
    .O_PULSE_CURR_LIMIT(pcl), .O_CLOSED_LOOP(cl), .O_ROTOR_SECTOR(sec));
  bmss_motor mot (.i_clk(clk), .i_spin(spin), .i_fwd(fwd), .i_hs(hs), .i_ls(ls), .o_cmp_uv(uv),
    .o_cmp_uw(uw), .o_curr_hit(hit));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  task summarize;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask : chk

  // waits on pready alone; the cycle ceiling cuts a dead slave short
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    r = prdata;
    e = perr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask : apb

  task wait_st(input logic [7:0] s);
    for (int k = 0; k < 6000; k++)
    begin
      apb(1'h0, ADDR_STATUS, 32'h0);
      if (r[7:0] === s)
        break;
    end
    chk(r[7:0], s);
  endtask : wait_st

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      fails++;
      summarize();
    end
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk(r, rows[i].x);
      chk(e, rows[i].er);
    end
    apb(1'h1, ADDR_ACCEL, 32'h0000_010F);
    apb(1'h1, ADDR_CTRL, 32'h0010_0401);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(r[7:0], 8'h01);
    chk({csel, pcl}, 6'h10);
    stby <= 1'h0;
    wait_st(8'h02);
    chk(hiz, 1'h1);
    wait_st(8'h04);
    chk({hs, ls}, 6'h07);
    wait_st(8'h08);
    chk({hs, ls, clen}, 7'h29);
    dir <= 1'h1;
    repeat (3) @(posedge clk);
    chk({hiz, hs, ls}, 7'h40);
    wait_st(8'h08);
    chk({hs, ls}, 6'h22);
    wait_st(8'h80);
    chk(cl, 1'h1);
    // spinning forward: one 96-cycle turn decides, well before the stationary timeout
    stby <= 1'h1;
    dir <= 1'h0;
    spin <= 1'h1;
    @(posedge clk);
    stby <= 1'h0;
    repeat (130) @(posedge clk);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(r[7:0], 8'h80);
    stby <= 1'h1;
    fwd <= 1'h0;
    apb(1'h1, ADDR_CTRL, 32'h0010_0383);
    stby <= 1'h0;
    wait_st(8'h20);
    chk(clen, 1'h1);
    spin <= 1'h0;
    wait_st(8'h40);
    stby <= 1'h1;
    apb(1'h1, ADDR_CTRL, 32'h0010_2000);
    @(posedge clk);
    chk(pcl, 4'h1);
    stby <= 1'h0;
    wait_st(8'h10);
    wait_st(8'h40);
    chk(sec, 3'h0);
    // brake first, then position pulses with both switches released between them
    stby <= 1'h1;
    apb(1'h1, ADDR_CTRL, 32'h0010_2404);
    stby <= 1'h0;
    wait_st(8'h04);
    wait_st(8'h10);
    wait_st(8'h40);
    chk(sec, 3'h0);
    summarize();
  end
endmodule : tb_top
